/* sim/test_switch_misc_control_regs.sv */
// Purpose: Self-checking bench for the switch miscellaneous control register bank.
// Assumes: Zero-wait APB slave; the sleep unit is shortened to four clock cycles.
// Notes: A monitor compares each bus answer with the oldest note queued by the driver.
`default_nettype none
module test_switch_misc_control_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int UNIT = 4;
    logic pclk, presetn, psel, penable, pwrite, energy_present, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic host_clk_pd_en, core_clk_pd_en, pll_pd_en, low_power_req;
    logic first_indicator_pin, second_indicator_pin;
    logic [2:0] invalid_vlan_fwd_map;
    smc_pkg::smc_port_status_t port_status;
    smc_pkg::smc_tag_insert_t tag_insert_en;
    smc_pkg::smc_pwr_mode_t pwr_mode;
    int fail_count, check_count, n;
    logic [33:0] notes[$];
    logic [33:0] note;
    logic [11:0] addrs[4];
    logic [7:0] masks[4], rsts[4];
    logic [31:0] v[4];

    smc_regs #(.UNIT_CYC(UNIT)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_status(port_status),
        .energy_present(energy_present), .tag_insert_en(tag_insert_en),
        .host_clk_pd_en(host_clk_pd_en), .core_clk_pd_en(core_clk_pd_en),
        .pll_pd_en(pll_pd_en), .pwr_mode(pwr_mode), .low_power_req(low_power_req),
        .invalid_vlan_fwd_map(invalid_vlan_fwd_map),
        .first_indicator_pin(first_indicator_pin), .second_indicator_pin(second_indicator_pin));

    // Counts every comparison and reports a mismatch at once.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    // Runs one transfer from just after a rising edge and holds it until pready is sampled.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        notes.push_back({wr, err, exp});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 20) begin
            check("pready", 32'h0, 32'h1);
            end_sim();
        end
    endtask : apb

    // The clock toggles every half period of 2.5 ns.
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Takes the oldest note whenever the slave answers and compares the answer with it.
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            note = notes.pop_front();
            check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
            if (!note[33]) begin
                check("prdata", prdata, note[31:0]);
            end
        end
    end

    // Main sequence: reset values, register traffic, indicator modes and sleep entry.
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        port_status = 6'h0;
        energy_present = 1'b0;
        addrs = '{smc_pkg::ADDR_TAG_INSERT, smc_pkg::ADDR_PWR_IND, smc_pkg::ADDR_SLEEP,
                  smc_pkg::ADDR_INVLAN};
        masks = '{smc_pkg::MASK_TAG_INSERT, smc_pkg::MASK_PWR_IND, smc_pkg::MASK_SLEEP,
                  smc_pkg::MASK_INVLAN};
        rsts = '{8'h00, 8'h00, 8'h50, 8'h00};
        void'($urandom(32'h08c90773));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, addrs[i], 32'h0, {24'h0, rsts[i]}, 1'b0);
        end
        check("power enables", {host_clk_pd_en, core_clk_pd_en}, 32'h0);
        check("power mode", pwr_mode, 32'h0);
        // Random words with reserved bits forced high, then read back through the masks.
        for (int i = 0; i < 4; i++) begin
            v[i] = $urandom() | 32'hc0;
            apb(1'b1, addrs[i], v[i], 32'h0, 1'b0);
        end
        check("tag insert", tag_insert_en, v[0][5:0]);
        check("host clock power-down", host_clk_pd_en, v[1][7]);
        check("core clock power-down", core_clk_pd_en, v[1][6]);
        check("pll power-down", pll_pd_en, v[1][2]);
        check("invalid vlan map", invalid_vlan_fwd_map, v[3][6:4]);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, addrs[i], 32'h0, {24'h0, v[i][7:0] & masks[i]}, 1'b0);
        end
        apb(1'b1, 12'h314, 32'hff, 32'h0, 1'b1);
        apb(1'b0, 12'h314, 32'h0, 32'h0, 1'b1);
        // Every indicator mode, plain and debug, and every power mode.
        for (int k = 0; k < 8; k++) begin
            port_status <= 6'($urandom());
            apb(1'b1, smc_pkg::ADDR_PWR_IND, {26'h0, k[1:0], k[2], 1'b0, k[1:0]}, 32'h0, 1'b0);
            @(posedge pclk);
            check("power mode", pwr_mode, k[1:0]);
            check("first pin", first_indicator_pin, k[2] ? !port_status.device_ready :
                k[0] ? port_status.link :
                port_status.link && port_status.activity);
            check("second pin", second_indicator_pin, k[2] ? !port_status.energy_stretched :
                k[1] ? port_status.duplex : k[0] ? port_status.activity :
                port_status.speed);
        end
        // Sleep of two units; an energy pulse must restart the idle count.
        apb(1'b1, smc_pkg::ADDR_SLEEP, 32'h2, 32'h0, 1'b0);
        apb(1'b1, smc_pkg::ADDR_PWR_IND, 32'h1, 32'h0, 1'b0);
        repeat (4) @(posedge pclk);
        check("early sleep", low_power_req, 32'h0);
        energy_present <= 1'b1;
        @(posedge pclk);
        energy_present <= 1'b0;
        repeat (6) @(posedge pclk);
        check("sleep after energy", low_power_req, 32'h0);
        n = 0;
        while (low_power_req !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        check("sleep entry", low_power_req, 32'h1);
        energy_present <= 1'b1;
        repeat (2) @(posedge pclk);
        check("wake on energy", low_power_req, 32'h0);
        check("pending notes", notes.size(), 32'h0);
        end_sim();
    end
endmodule : test_switch_misc_control_regs
`default_nettype wire

/* src/smc_pkg.sv */
// Purpose: Shared constants and types for the switch miscellaneous control bank.
// Assumes: APB with 32-bit data, one aligned word per 8-bit register.
// Notes: Register indices are byte offsets of the bank; bus address is four times them.
`default_nettype none
package smc_pkg;
    // Register indices and their APB byte addresses.
    localparam logic [7:0] IDX_TAG_INSERT = 8'hc2;
    localparam logic [7:0] IDX_PWR_IND = 8'hc3;
    localparam logic [7:0] IDX_SLEEP = 8'hc4;
    localparam logic [7:0] IDX_INVLAN = 8'hc6;
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_TAG_INSERT = {2'h0, IDX_TAG_INSERT, 2'h0};
    localparam logic [11:0] ADDR_PWR_IND = {2'h0, IDX_PWR_IND, 2'h0};
    localparam logic [11:0] ADDR_SLEEP = {2'h0, IDX_SLEEP, 2'h0};
    localparam logic [11:0] ADDR_INVLAN = {2'h0, IDX_INVLAN, 2'h0};

    // Writable masks; all other bits are reserved and read zero.
    localparam logic [7:0] MASK_TAG_INSERT = 8'h3f;
    localparam logic [7:0] MASK_PWR_IND = 8'hff;
    localparam logic [7:0] MASK_SLEEP = 8'hff;
    localparam logic [7:0] MASK_INVLAN = 8'h7f;

    // Reset values.
    localparam logic [7:0] RST_TAG_INSERT = 8'h00;
    localparam logic [7:0] RST_PWR_IND = 8'h00;
    localparam logic [7:0] RST_SLEEP = 8'h50;
    localparam logic [7:0] RST_INVLAN = 8'h00;

    // Field positions in the power and indicator register.
    localparam int POS_HOST_CLK_PD = 7;
    localparam int POS_CORE_CLK_PD = 6;
    localparam int POS_IND_MODE = 4;
    localparam int POS_IND_DEBUG = 3;
    localparam int POS_PLL_PD = 2;
    localparam int POS_PWR_MODE = 0;
    // Field position of the invalid VLAN forward map.
    localparam int POS_INVLAN_MAP = 4;

    // Sleep delay unit.
    localparam int CLK_PERIOD_NS = 5;
    localparam int SLEEP_UNIT_MS = 20;
    localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int UNIT_CNT_W = 22;

    typedef enum logic [1:0] {
        SMC_PWR_NORMAL,
        SMC_PWR_ENERGY_DETECT,
        SMC_PWR_SOFT_DOWN,
        SMC_PWR_SAVING
    } smc_pwr_mode_t;

    typedef enum logic [1:0] {
        SMC_IND_LINKACT_SPEED,
        SMC_IND_LINK_ACT,
        SMC_IND_LINKACT_DUPLEX,
        SMC_IND_LINK_DUPLEX
    } smc_ind_mode_t;

    // Port status that feeds the indicator pins.
    typedef struct packed {
        logic link;
        logic activity;
        logic speed;
        logic duplex;
        logic energy_stretched;
        logic device_ready;
    } smc_port_status_t;

    // Per source/egress pair default-tag insert enables.
    typedef struct packed {
        logic src1_to_p2;
        logic src1_to_p3;
        logic src2_to_p1;
        logic src2_to_p3;
        logic src3_to_p1;
        logic src3_to_p2;
    } smc_tag_insert_t;
endpackage : smc_pkg
`default_nettype wire

/* src/smc_regs.sv */
// Purpose: APB register bank for tag insertion, power, indicator and sleep control.
// Assumes: pclk at 200 MHz, presetn asynchronous active low, status inputs synchronous.
// Notes: Zero-wait APB slave; unmapped addresses answer with pslverr and read zero.
`default_nettype none
// Behaviour
// - Bits 5 and 4 insert port 1 default tag at egress ports 2 and 3.
// - Bits 3 and 2 insert port 2 default tag at egress ports 1 and 3.
// - Bits 1 and 0 insert port 3 default tag at egress ports 1 and 2.
// - Power bit 7 enables host interface clock tree power-down, reset off.
// - Power bit 6 enables switch core clock tree power-down, reset off.
// - Indicator mode field selects link, activity, speed, duplex on the two pins.
// - Debug bit 3 drives the first pin with inverted ready and the second pin with inverted energy.
// - Power bit 2 enables PLL power-down.
// - Two-bit power mode: normal, energy detect, software down, power saving.
// - Sleep delay register resets to 0x50, which is 1.6 seconds.
// - Bits 6 to 4 give invalid VLAN forward port map, reset zero.
module smc_regs #(
    parameter int UNIT_CYC = smc_pkg::SLEEP_UNIT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [smc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire smc_pkg::smc_port_status_t port_status,
    input wire logic energy_present,
    output smc_pkg::smc_tag_insert_t tag_insert_en,
    output logic host_clk_pd_en,
    output logic core_clk_pd_en,
    output logic pll_pd_en,
    output smc_pkg::smc_pwr_mode_t pwr_mode,
    output logic low_power_req,
    output logic [2:0] invalid_vlan_fwd_map,
    output logic first_indicator_pin,
    output logic second_indicator_pin
);
    logic [7:0] tag_q;
    logic [7:0] pwr_q;
    logic [7:0] sleep_q;
    logic [7:0] invlan_q;
    logic [31:0] rdata_q;
    logic ready_q;
    logic err_q;
    logic [smc_pkg::UNIT_CNT_W-1:0] tick_q;
    logic [smc_pkg::UNIT_CNT_W-1:0] tick_d;
    logic [7:0] units_q;
    logic [7:0] units_d;
    logic lowp_q;
    logic ind0_q;
    logic ind1_q;

    // Address decode and phase qualification.
    wire setup = psel && !penable;
    wire wr_en = psel && penable && pready && pwrite;
    wire hit_tag = paddr == smc_pkg::ADDR_TAG_INSERT;
    wire hit_pwr = paddr == smc_pkg::ADDR_PWR_IND;
    wire hit_sleep = paddr == smc_pkg::ADDR_SLEEP;
    wire hit_invlan = paddr == smc_pkg::ADDR_INVLAN;
    wire hit_any = hit_tag || hit_pwr || hit_sleep || hit_invlan;

    // Read mux; reserved bits are held at zero in the stored values.
    wire [7:0] rd_byte = hit_tag ? tag_q : hit_pwr ? pwr_q : hit_sleep ? sleep_q :
                         hit_invlan ? invlan_q : 8'h00;

    // Masked write data keeps reserved bits at zero.
    wire [7:0] wtag = pwdata[7:0] & smc_pkg::MASK_TAG_INSERT;
    wire [7:0] wpwr = pwdata[7:0] & smc_pkg::MASK_PWR_IND;
    wire [7:0] wsleep = pwdata[7:0] & smc_pkg::MASK_SLEEP;
    wire [7:0] winvlan = pwdata[7:0] & smc_pkg::MASK_INVLAN;

    // Field views of the power and indicator register.
    wire [1:0] ind_mode = pwr_q[smc_pkg::POS_IND_MODE +: 2];
    wire ind_debug = pwr_q[smc_pkg::POS_IND_DEBUG];
    wire [1:0] mode_bits = pwr_q[smc_pkg::POS_PWR_MODE +: 2];
    wire energy_detect_mode = mode_bits == 2'(smc_pkg::SMC_PWR_ENERGY_DETECT);

    // APB answer: ready one cycle after setup, so every access has zero wait states.
    // Read data is captured in the setup cycle, after any write that landed before it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ready_q <= setup;
            err_q <= setup && !hit_any;
            rdata_q <= setup ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // Register storage; writes land at the access edge with pready high.
    // Masking at the write keeps reserved bits zero without gating the read path.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tag_q <= smc_pkg::RST_TAG_INSERT;
            pwr_q <= smc_pkg::RST_PWR_IND;
            sleep_q <= smc_pkg::RST_SLEEP;
            invlan_q <= smc_pkg::RST_INVLAN;
        end else if (wr_en) begin
            if (hit_tag) tag_q <= wtag;
            if (hit_pwr) pwr_q <= wpwr;
            if (hit_sleep) sleep_q <= wsleep;
            if (hit_invlan) invlan_q <= winvlan;
        end
    end

    // No-energy timer: counts 20 ms units while idle, any energy restarts it.
    // The unit count saturates so that a long quiet spell never wraps back to awake.
    // Leaving energy detect mode clears both counters, so a later return starts afresh.
    wire idle = energy_detect_mode && !energy_present;
    wire unit_done = tick_q == smc_pkg::UNIT_CNT_W'(UNIT_CYC - 1);
    always_comb begin
        tick_d = unit_done ? '0 : tick_q + 1'b1;
        units_d = (unit_done && units_q != 8'hff) ? units_q + 8'h01 : units_q;
        if (!idle) begin
            tick_d = '0;
            units_d = 8'h00;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= '0;
            units_q <= 8'h00;
            lowp_q <= 1'b0;
        end else begin
            tick_q <= tick_d;
            units_q <= units_d;
            lowp_q <= idle && units_q >= sleep_q;
        end
    end

    // Indicator pin selection per mode, or the inverted debug signals.
    logic ind0_d;
    logic ind1_d;
    always_comb begin
        ind0_d = port_status.link;
        ind1_d = port_status.duplex;
        unique case (smc_pkg::smc_ind_mode_t'(ind_mode))
            smc_pkg::SMC_IND_LINKACT_SPEED: begin
                ind0_d = port_status.link && port_status.activity;
                ind1_d = port_status.speed;
            end
            smc_pkg::SMC_IND_LINK_ACT: begin
                ind0_d = port_status.link;
                ind1_d = port_status.activity;
            end
            smc_pkg::SMC_IND_LINKACT_DUPLEX: begin
                ind0_d = port_status.link && port_status.activity;
                ind1_d = port_status.duplex;
            end
            smc_pkg::SMC_IND_LINK_DUPLEX: begin
                ind0_d = port_status.link;
                ind1_d = port_status.duplex;
            end
        endcase
        if (ind_debug) begin
            ind0_d = !port_status.device_ready;
            ind1_d = !port_status.energy_stretched;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ind0_q <= 1'b0;
            ind1_q <= 1'b0;
        end else begin
            ind0_q <= ind0_d;
            ind1_q <= ind1_d;
        end
    end

    // Outputs straight from the registers.
    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;
    assign tag_insert_en = smc_pkg::smc_tag_insert_t'(tag_q[5:0]);
    assign host_clk_pd_en = pwr_q[smc_pkg::POS_HOST_CLK_PD];
    assign core_clk_pd_en = pwr_q[smc_pkg::POS_CORE_CLK_PD];
    assign pll_pd_en = pwr_q[smc_pkg::POS_PLL_PD];
    assign pwr_mode = smc_pkg::smc_pwr_mode_t'(mode_bits);
    assign low_power_req = lowp_q;
    assign invalid_vlan_fwd_map = invlan_q[smc_pkg::POS_INVLAN_MAP +: 3];
    assign first_indicator_pin = ind0_q;
    assign second_indicator_pin = ind1_q;

    // Helper for the sleep check: consecutive quiet cycles seen in energy detect mode.
    // It saturates rather than wraps, so a very long quiet spell cannot look short.
    logic [31:0] quiet_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet_q <= 32'h0000_0000;
        end else if (!idle) begin
            quiet_q <= 32'h0000_0000;
        end else if (quiet_q != 32'hffff_ffff) begin
            quiet_q <= quiet_q + 32'h0000_0001;
        end
    end

    // Checks on the bank's behaviour.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    tag_pair_map_a: assert property (wr_en && hit_tag |=>
        tag_insert_en.src1_to_p2 == $past(pwdata[5]) && tag_insert_en.src1_to_p3 == $past(pwdata[4]))
        else $error("Port 1 tag insert bits wrong.");
    tag_src2_map_a: assert property (wr_en && hit_tag |=>
        tag_insert_en.src2_to_p1 == $past(pwdata[3]) && tag_insert_en.src2_to_p3 == $past(pwdata[2]))
        else $error("Port 2 tag insert bits wrong.");
    tag_src3_map_a: assert property (wr_en && hit_tag |=>
        tag_insert_en.src3_to_p1 == $past(pwdata[1]) && tag_insert_en.src3_to_p2 == $past(pwdata[0]))
        else $error("Port 3 tag insert bits wrong.");
    clk_pd_bits_a: assert property (wr_en && hit_pwr |=>
        host_clk_pd_en == $past(pwdata[7]) && core_clk_pd_en == $past(pwdata[6])
        && pll_pd_en == $past(pwdata[2]))
        else $error("Power-down enables do not follow write.");
    ind_mode_sel_a: assert property (!ind_debug && ind_mode == 2'b01 |=>
        first_indicator_pin == $past(port_status.link)
        && second_indicator_pin == $past(port_status.activity))
        else $error("Indicator mode selection wrong.");
    ind_debug_out_a: assert property (ind_debug |=>
        first_indicator_pin != $past(port_status.device_ready)
        && second_indicator_pin != $past(port_status.energy_stretched))
        else $error("Debug indicator output not inverted.");
    pwr_mode_wr_a: assert property (wr_en && hit_pwr |=> pwr_mode == $past(pwdata[1:0]))
        else $error("Power mode does not follow write.");
    sleep_energy_a: assert property (energy_present |=> !low_power_req ##1 !low_power_req)
        else $error("Low power entered despite energy.");
    sleep_reset_a: assert property ($rose(presetn) |-> sleep_q == 8'h50)
        else $error("Sleep delay reset value wrong.");
    invlan_map_a: assert property (wr_en && hit_invlan |=>
        invalid_vlan_fwd_map == $past(pwdata[6:4]))
        else $error("Invalid VLAN map does not follow write.");
    reserved_zero_a: assert property (tag_q[7:6] == 2'b00 && invlan_q[7] == 1'b0)
        else $error("Reserved bit not zero.");

    // Reset values of the control outputs.
    tag_reset_a: assert property (
        $rose(presetn) |-> tag_insert_en == '0)
        else $error("Tag insert enables not clear after reset.");
    pwr_reset_a: assert property (
        $rose(presetn) |-> !host_clk_pd_en && !core_clk_pd_en
        && pwr_mode == smc_pkg::SMC_PWR_NORMAL)
        else $error("Power control outputs not at reset values.");
    ind_reset_a: assert property ($rose(presetn) |-> ind_mode == 2'b00)
        else $error("Indicator mode not at reset value.");
    invlan_reset_a: assert property (
        $rose(presetn) |-> invalid_vlan_fwd_map == 3'b000)
        else $error("Invalid VLAN map not clear after reset.");

    // Control outputs change only on a write to their own register.
    tag_hold_a: assert property (
        !(wr_en && hit_tag) |=> $stable(tag_insert_en))
        else $error("Tag insert enables changed without a write.");
    pwr_hold_a: assert property (
        !(wr_en && hit_pwr) |=> $stable(host_clk_pd_en) && $stable(core_clk_pd_en)
        && $stable(pll_pd_en) && $stable(pwr_mode))
        else $error("Power controls changed without a write.");
    invlan_hold_a: assert property (
        !(wr_en && hit_invlan) |=> $stable(invalid_vlan_fwd_map))
        else $error("Invalid VLAN map changed without a write.");

    // Sleep delay storage and the no-energy rule.
    sleep_wr_a: assert property (
        wr_en && hit_sleep |=> sleep_q == $past(pwdata[7:0]))
        else $error("Sleep delay does not follow write.");
    lowp_mode_a: assert property (!energy_detect_mode |=> !low_power_req)
        else $error("Low power requested outside energy detect mode.");
    sleep_quiet_a: assert property (
        low_power_req |-> quiet_q >= 32'($past(sleep_q)) * 32'(UNIT_CYC))
        else $error("Low power entered before the quiet time ran out.");

    // Indicator selection for the remaining modes.
    ind_speed_sel_a: assert property (!ind_debug && ind_mode == 2'b00 |=>
        first_indicator_pin == $past(port_status.link && port_status.activity)
        && second_indicator_pin == $past(port_status.speed))
        else $error("Indicator speed mode selection wrong.");
    ind_duplex_sel_a: assert property (!ind_debug && ind_mode == 2'b10 |=>
        first_indicator_pin == $past(port_status.link && port_status.activity)
        && second_indicator_pin == $past(port_status.duplex))
        else $error("Indicator duplex mode selection wrong.");
    ind_link_dup_a: assert property (!ind_debug && ind_mode == 2'b11 |=>
        first_indicator_pin == $past(port_status.link)
        && second_indicator_pin == $past(port_status.duplex))
        else $error("Indicator link and duplex selection wrong.");

    // Bus answers keep reserved and unused bits at zero.
    unmapped_err_a: assert property (setup && !hit_any |=> pready && pslverr
        && prdata == 32'h0000_0000)
        else $error("Unmapped access not refused.");
    rsvd_read_zero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000
        && !(hit_tag && prdata[7:6] != 2'b00) && !(hit_invlan && prdata[7]))
        else $error("Reserved read bits not zero.");

    write_cover_c: cover property (wr_en && hit_pwr);
    sleep_cover_c: cover property (!low_power_req ##1 low_power_req);
    error_cover_c: cover property (pslverr && pready);
    debug_cover_c: cover property (ind_debug && first_indicator_pin);
    quiet_cover_c: cover property (energy_detect_mode && energy_present ##1 energy_detect_mode && !energy_present);
endmodule : smc_regs
`default_nettype wire
